// ==== tcc8_regs.svh ====
`ifndef TCC8_REGS_SVH
`define TCC8_REGS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte address on the plain register port)
// ----------------------------------------------------------------------------
`define TCC8_ADR_CTRL_A      3'h0
`define TCC8_ADR_CTRL_B      3'h1
`define TCC8_ADR_COUNTER     3'h2
`define TCC8_ADR_CMP_A       3'h3
`define TCC8_ADR_CMP_B       3'h4
`define TCC8_ADR_FLAGS       3'h5
`define TCC8_ADR_MASK        3'h6

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
// timer_control_a
`define TCC8_CA_WGM_LO       1:0
`define TCC8_CA_COMB         5:4
`define TCC8_CA_COMA         7:6
// timer_control_b
`define TCC8_CB_CS           2:0
`define TCC8_CB_WGM2         3
`define TCC8_CB_FOCB         6
`define TCC8_CB_FOCA         7
// flag and mask registers
`define TCC8_FL_OVF          0
`define TCC8_FL_CMPA         1
`define TCC8_FL_CMPB         2
`define TCC8_FL_MSB          2

// ----------------------------------------------------------------------------
// reset values and counter extremes
// ----------------------------------------------------------------------------
`define TCC8_RST_BYTE        8'h00
`define TCC8_RST_FLAGS       3'h0
`define TCC8_BOTTOM          8'h00
`define TCC8_MAX             8'hff

// ----------------------------------------------------------------------------
// prescaler taps: log2 of each division ratio
// ----------------------------------------------------------------------------
`define TCC8_PRE_BITS        10
`define TCC8_PRE_DIV8        4'h3
`define TCC8_PRE_DIV64       4'h6
`define TCC8_PRE_DIV256      4'h8
`define TCC8_PRE_DIV1024     4'ha

`endif

// ==== tcc8_pkg.sv ====
package tcc8_pkg;

    // ------------------------------------------------------------------------
    // clock source select codes
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        TCC8_CS_OFF     = 3'h0,
        TCC8_CS_DIV1    = 3'h1,
        TCC8_CS_DIV8    = 3'h2,
        TCC8_CS_DIV64   = 3'h3,
        TCC8_CS_DIV256  = 3'h4,
        TCC8_CS_DIV1024 = 3'h5,
        TCC8_CS_EXT_FALL= 3'h6,
        TCC8_CS_EXT_RISE= 3'h7
    } tcc8_cs_t;

    // ------------------------------------------------------------------------
    // waveform mode codes; 4 and 6 are reserved and behave as normal
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        TCC8_WGM_NORMAL   = 3'h0,
        TCC8_WGM_PC_MAX   = 3'h1,
        TCC8_WGM_CTC      = 3'h2,
        TCC8_WGM_FAST_MAX = 3'h3,
        TCC8_WGM_PC_CMPA  = 3'h5,
        TCC8_WGM_FAST_CMPA= 3'h7
    } tcc8_wgm_t;

    // ------------------------------------------------------------------------
    // waveform generator families
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        TCC8_KIND_NONPWM = 2'h0,
        TCC8_KIND_FAST   = 2'h1,
        TCC8_KIND_PHASE  = 2'h3
    } tcc8_kind_t;

endpackage

// ==== tcc8_tick_if.sv ====
interface tcc8_tick_if;
    logic [2:0] clock_source_select;
    logic       timer_tick;

    modport src (input clock_source_select, output timer_tick);
    modport snk (output clock_source_select, input timer_tick);
endinterface

// ==== tcc8_tick.sv ====
`include "tcc8_regs.svh"

module tcc8_tick (
    input  wire logic      clk_i,
    input  wire logic      rst_b_i,
    input  wire logic      external_count_pin_i,
    tcc8_tick_if.src       tk
);

    // ------------------------------------------------------------------------
    // free running prescaler
    // ------------------------------------------------------------------------
    logic [`TCC8_PRE_BITS-1:0] pre_ff;
    logic [2:0]                pin_sync_ff;
    wire  logic                pin_rise;
    wire  logic                pin_fall;

    function automatic logic tcc8_tap(input logic [`TCC8_PRE_BITS-1:0] p, input logic [3:0] n);
        logic [`TCC8_PRE_BITS:0] m;
        m = ({{`TCC8_PRE_BITS{1'b0}}, 1'b1} << n) - {{`TCC8_PRE_BITS{1'b0}}, 1'b1};
        return (p & m[`TCC8_PRE_BITS-1:0]) == m[`TCC8_PRE_BITS-1:0];
    endfunction

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + {{(`TCC8_PRE_BITS-1){1'b0}}, 1'b1};
        end
    end

    // ------------------------------------------------------------------------
    // external pin: two-stage synchroniser, third stage for edge detection
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_sync_ff <= 3'h0;
        end else begin
            pin_sync_ff <= {pin_sync_ff[1:0], external_count_pin_i};
        end
    end

    assign pin_rise = pin_sync_ff[1] & ~pin_sync_ff[2];
    assign pin_fall = ~pin_sync_ff[1] & pin_sync_ff[2];

    // ------------------------------------------------------------------------
    // tick select: one-cycle enable, never more than one per clock
    // ------------------------------------------------------------------------
    always_comb begin
        case (tcc8_pkg::tcc8_cs_t'(tk.clock_source_select))
            tcc8_pkg::TCC8_CS_OFF:      tk.timer_tick = 1'b0;
            tcc8_pkg::TCC8_CS_DIV1:     tk.timer_tick = 1'b1;
            tcc8_pkg::TCC8_CS_DIV8:     tk.timer_tick = tcc8_tap(pre_ff, `TCC8_PRE_DIV8);
            tcc8_pkg::TCC8_CS_DIV64:    tk.timer_tick = tcc8_tap(pre_ff, `TCC8_PRE_DIV64);
            tcc8_pkg::TCC8_CS_DIV256:   tk.timer_tick = tcc8_tap(pre_ff, `TCC8_PRE_DIV256);
            tcc8_pkg::TCC8_CS_DIV1024:  tk.timer_tick = tcc8_tap(pre_ff, `TCC8_PRE_DIV1024);
            tcc8_pkg::TCC8_CS_EXT_FALL: tk.timer_tick = pin_fall;
            tcc8_pkg::TCC8_CS_EXT_RISE: tk.timer_tick = pin_rise;
            default:                    tk.timer_tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    tick_off_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        tk.clock_source_select == 3'h0 |-> !tk.timer_tick)
        else $error("tick while clock source is off");

    ext_rise_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (tk.clock_source_select == 3'h7 && $rose(pin_sync_ff[1])) |-> tk.timer_tick)
        else $error("external rising edge gave no tick");

endmodule // tcc8_tick

// ==== tcc8_core.sv ====
// Functional notes
// - counter and compares: eight-bit, read/write
// - three flags, one mask bit each
// - tick from prescaler or external pin edge
// - source select zero stops all ticks
// - both compares checked on each tick, except the tick after a counter write
// - compare match sets its flag
// - bottom is 0x00, max is 0xff
// - top is 0xff or compare A
// - each tick clears, increments or decrements
// - counter accessible with or without ticks
// - counter write beats count or clear
// - mode field split across both controls
// - overflow flag set where mode says
// - two waveform outputs, pwm or frequency
// - internal top and bottom indications
// - compare flag set on following tick
// - flag cleared by service or one-write
// - normal mode wraps, overflow at zero
// - ctc clears counter at compare A
`include "tcc8_regs.svh"

module tcc8_core (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       external_count_pin_i,
    input  wire logic [2:0] int_ack_i,
    output logic      [2:0] int_req_o,
    output logic            compare_output_a_o,
    output logic            compare_output_b_o
);

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    logic [7:0]              ctla_ff;
    logic [3:0]              ctlb_ff;
    logic [7:0]              counter_value_ff;
    logic [7:0]              bufa_ff;
    logic [7:0]              bufb_ff;
    logic [7:0]              compare_value_a_ff;
    logic [7:0]              compare_value_b_ff;
    logic [`TCC8_FL_MSB:0]   flags_ff;
    logic [`TCC8_FL_MSB:0]   mask_ff;
    logic                    down_ff;
    logic                    block_ff;
    logic [7:0]              rdata_ff;
    logic [2:0]              int_req_ff;
    logic                    oca_ff;
    logic                    ocb_ff;

    // ------------------------------------------------------------------------
    // tick source
    // ------------------------------------------------------------------------
    tcc8_tick_if tick_if ();

    tcc8_tick u_tick (
        .clk_i                (clk_i),
        .rst_b_i              (rst_b_i),
        .external_count_pin_i (external_count_pin_i),
        .tk                   (tick_if)
    );

    wire logic [2:0] clock_source_select = ctlb_ff[`TCC8_CB_CS];
    assign tick_if.clock_source_select = clock_source_select;
    wire logic       timer_tick          = tick_if.timer_tick;

    // ------------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------------
    wire logic wr_ctla = wr_i && addr_i == `TCC8_ADR_CTRL_A;
    wire logic wr_ctlb = wr_i && addr_i == `TCC8_ADR_CTRL_B;
    wire logic wr_cnt  = wr_i && addr_i == `TCC8_ADR_COUNTER;
    wire logic wr_cmpa = wr_i && addr_i == `TCC8_ADR_CMP_A;
    wire logic wr_cmpb = wr_i && addr_i == `TCC8_ADR_CMP_B;
    wire logic wr_flag = wr_i && addr_i == `TCC8_ADR_FLAGS;
    wire logic wr_mask = wr_i && addr_i == `TCC8_ADR_MASK;

    // ------------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------------
    function automatic tcc8_pkg::tcc8_kind_t tcc8_kind(input logic [2:0] m);
        if (m[0] && m[1]) begin
            return tcc8_pkg::TCC8_KIND_FAST;
        end else if (m[0]) begin
            return tcc8_pkg::TCC8_KIND_PHASE;
        end else begin
            return tcc8_pkg::TCC8_KIND_NONPWM;
        end
    endfunction

    wire logic [2:0] waveform_mode = {ctlb_ff[`TCC8_CB_WGM2], ctla_ff[`TCC8_CA_WGM_LO]};
    wire tcc8_pkg::tcc8_kind_t kind = tcc8_kind(waveform_mode);
    wire logic is_ctc   = waveform_mode == tcc8_pkg::TCC8_WGM_CTC;
    wire logic is_pwm   = kind != tcc8_pkg::TCC8_KIND_NONPWM;
    wire logic is_phase = kind == tcc8_pkg::TCC8_KIND_PHASE;
    wire logic top_cmpa = is_ctc || (waveform_mode[2] && waveform_mode[0]);

    // ------------------------------------------------------------------------
    // top / bottom / max and compare detection
    // ------------------------------------------------------------------------
    wire logic [7:0] top_value = top_cmpa ? compare_value_a_ff : `TCC8_MAX;
    wire logic at_top    = counter_value_ff == top_value;
    wire logic at_bottom = counter_value_ff == `TCC8_BOTTOM;
    wire logic at_max    = counter_value_ff == `TCC8_MAX;
    wire logic match_a   = counter_value_ff == compare_value_a_ff;
    wire logic match_b   = counter_value_ff == compare_value_b_ff;
    wire logic count_go  = timer_tick && !wr_cnt;

    // ------------------------------------------------------------------------
    // counter next state
    // ------------------------------------------------------------------------
    logic [7:0] step_value;
    logic       step_down;

    always_comb begin
        step_down = 1'b0;
        if (!is_phase) begin
            step_value = at_top ? `TCC8_BOTTOM : counter_value_ff + 8'h01;
        end else if (!down_ff) begin
            step_down  = at_top;
            step_value = at_top ? counter_value_ff - 8'h01 : counter_value_ff + 8'h01;
        end else begin
            step_down  = !at_bottom;
            step_value = at_bottom ? counter_value_ff + 8'h01 : counter_value_ff - 8'h01;
        end
    end

    wire logic [7:0] nxt_counter = wr_cnt ? wdata_i : (count_go ? step_value : counter_value_ff);
    wire logic       nxt_down    = is_phase && (count_go ? step_down : down_ff);

    // overflow: at max in ctc, at the turn at bottom in phase correct, else when wrapping to zero
    wire logic ovf_evt = count_go && (is_ctc ? at_max :
                         is_phase ? (down_ff && at_bottom) : at_top);

    // a counter write blocks matches until the next tick has passed
    wire logic cmpa_evt = timer_tick && match_a && !block_ff && !wr_cnt;
    wire logic cmpb_evt = timer_tick && match_b && !block_ff && !wr_cnt;

    // ------------------------------------------------------------------------
    // compare registers: buffered in pwm modes, updated at top
    // ------------------------------------------------------------------------
    wire logic [7:0] nxt_bufa = wr_cmpa ? wdata_i : bufa_ff;
    wire logic [7:0] nxt_bufb = wr_cmpb ? wdata_i : bufb_ff;
    wire logic       cmp_load = !is_pwm || (count_go && at_top);

    // ------------------------------------------------------------------------
    // flags: a set in the same cycle as a clear wins
    // ------------------------------------------------------------------------
    wire logic [2:0] flag_set = {cmpb_evt, cmpa_evt, ovf_evt};
    wire logic [2:0] flag_clr = (wr_flag ? wdata_i[`TCC8_FL_MSB:0] : 3'h0) | int_ack_i;
    wire logic [2:0] nxt_flags = (flags_ff & ~flag_clr) | flag_set;
    wire logic [2:0] nxt_mask  = wr_mask ? wdata_i[`TCC8_FL_MSB:0] : mask_ff;

    // ------------------------------------------------------------------------
    // waveform generators
    // ------------------------------------------------------------------------
    function automatic logic tcc8_oc_next(
        input logic                 cur,
        input logic [1:0]           com,
        input tcc8_pkg::tcc8_kind_t k,
        input logic                 match,
        input logic                 wrap,
        input logic                 down
    );
        logic res;
        res = cur;
        case (k)
            tcc8_pkg::TCC8_KIND_NONPWM: begin
                if (match) begin
                    res = (com == 2'h1) ? ~cur : (com == 2'h2) ? 1'b0 : (com == 2'h3) ? 1'b1 : cur;
                end
            end
            tcc8_pkg::TCC8_KIND_FAST: begin
                if (match && com[1]) begin
                    res = com[0];
                end else if (wrap && com[1]) begin
                    res = ~com[0];
                end
            end
            tcc8_pkg::TCC8_KIND_PHASE: begin
                if (match && com[1]) begin
                    res = com[0] ^ down;
                end
            end
            default: res = cur;
        endcase
        return res;
    endfunction

    // force strobes act only outside pwm and do not touch flags or counter
    wire logic force_a = wr_ctlb && wdata_i[`TCC8_CB_FOCA] && !is_pwm;
    wire logic force_b = wr_ctlb && wdata_i[`TCC8_CB_FOCB] && !is_pwm;
    wire logic wrap    = count_go && at_top;

    wire logic nxt_oca = tcc8_oc_next(oca_ff, ctla_ff[`TCC8_CA_COMA], kind,
                                      cmpa_evt || force_a, wrap, down_ff);
    wire logic nxt_ocb = tcc8_oc_next(ocb_ff, ctla_ff[`TCC8_CA_COMB], kind,
                                      cmpb_evt || force_b, wrap, down_ff);

    // ------------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        case (addr_i)
            `TCC8_ADR_CTRL_A:  rd_mux = ctla_ff;
            `TCC8_ADR_CTRL_B:  rd_mux = {4'h0, ctlb_ff};
            `TCC8_ADR_COUNTER: rd_mux = counter_value_ff;
            `TCC8_ADR_CMP_A:   rd_mux = bufa_ff;
            `TCC8_ADR_CMP_B:   rd_mux = bufb_ff;
            `TCC8_ADR_FLAGS:   rd_mux = {5'h00, flags_ff};
            `TCC8_ADR_MASK:    rd_mux = {5'h00, mask_ff};
            default:           rd_mux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctla_ff            <= `TCC8_RST_BYTE;
            ctlb_ff            <= 4'h0;
            counter_value_ff   <= `TCC8_RST_BYTE;
            bufa_ff            <= `TCC8_RST_BYTE;
            bufb_ff            <= `TCC8_RST_BYTE;
            compare_value_a_ff <= `TCC8_RST_BYTE;
            compare_value_b_ff <= `TCC8_RST_BYTE;
            down_ff            <= 1'b0;
            block_ff           <= 1'b0;
        end else begin
            ctla_ff            <= wr_ctla ? wdata_i : ctla_ff;
            ctlb_ff            <= wr_ctlb ? wdata_i[3:0] : ctlb_ff;
            counter_value_ff   <= nxt_counter;
            bufa_ff            <= nxt_bufa;
            bufb_ff            <= nxt_bufb;
            compare_value_a_ff <= cmp_load ? nxt_bufa : compare_value_a_ff;
            compare_value_b_ff <= cmp_load ? nxt_bufb : compare_value_b_ff;
            down_ff            <= nxt_down;
            block_ff           <= wr_cnt || (block_ff && !timer_tick);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flags_ff   <= `TCC8_RST_FLAGS;
            mask_ff    <= `TCC8_RST_FLAGS;
            int_req_ff <= 3'h0;
            oca_ff     <= 1'b0;
            ocb_ff     <= 1'b0;
            rdata_ff   <= 8'h00;
        end else begin
            flags_ff   <= nxt_flags;
            mask_ff    <= nxt_mask;
            int_req_ff <= nxt_flags & nxt_mask;
            oca_ff     <= nxt_oca;
            ocb_ff     <= nxt_ocb;
            rdata_ff   <= rd_i ? rd_mux : 8'h00;
        end
    end

    assign rdata_o            = rdata_ff;
    assign int_req_o          = int_req_ff;
    assign compare_output_a_o = oca_ff;
    assign compare_output_b_o = ocb_ff;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    frozen_when_off_a: assert property (
        (clock_source_select == 3'h0 && !wr_cnt) |=> $stable(counter_value_ff))
        else $error("counter moved with clock source off");

    write_wins_a: assert property (
        wr_cnt |=> counter_value_ff == $past(wdata_i))
        else $error("counter write lost to count");

    cmp_flag_set_a: assert property (
        (timer_tick && match_a && !block_ff && !wr_cnt) |=> flags_ff[`TCC8_FL_CMPA])
        else $error("compare A match did not set flag");

    normal_wrap_a: assert property (
        (waveform_mode == 3'h0 && count_go && at_max)
        |=> counter_value_ff == 8'h00 && flags_ff[`TCC8_FL_OVF])
        else $error("normal mode wrap or overflow wrong");

    ctc_clear_a: assert property (
        (is_ctc && count_go && match_a) |=> counter_value_ff == 8'h00)
        else $error("ctc did not clear at compare A");

    up_count_a: assert property (
        (waveform_mode == 3'h0 && count_go && !at_max)
        |=> counter_value_ff == $past(counter_value_ff) + 8'h01)
        else $error("normal mode did not increment");

    irq_gate_a: assert property (
        (int_ack_i == 3'h0 && !wr_flag && !wr_mask) ##1 (int_ack_i == 3'h0)
        |-> int_req_o == (flags_ff & mask_ff))
        else $error("interrupt request not flag and mask");

    flag_w1c_a: assert property (
        (wr_flag && wdata_i[`TCC8_FL_OVF] && !ovf_evt) |=> !flags_ff[`TCC8_FL_OVF])
        else $error("overflow flag not cleared by one-write");

    block_match_a: assert property (
        (wr_cnt ##1 timer_tick) |=> !$rose(flags_ff[`TCC8_FL_CMPA]) && !$rose(flags_ff[`TCC8_FL_CMPB]))
        else $error("match not blocked after counter write");

    no_tick_flag_a: assert property (
        clock_source_select == 3'h0 |=> !$rose(flags_ff[`TCC8_FL_CMPA]) && !$rose(flags_ff[`TCC8_FL_CMPB]))
        else $error("compare flag set with clock source off");

    phase_turn_a: assert property (
        (is_phase && !top_cmpa && count_go && at_max && !down_ff) |=> counter_value_ff == 8'hfe && down_ff)
        else $error("phase correct count did not turn at top");

    flag_ack_a: assert property (
        (int_ack_i[`TCC8_FL_OVF] && !ovf_evt) |=> !flags_ff[`TCC8_FL_OVF])
        else $error("overflow flag not cleared by service");

    cmp_direct_a: assert property (
        (wr_cmpa && !is_pwm) |=> compare_value_a_ff == $past(wdata_i))
        else $error("compare A not active at once outside pwm");

    rdata_idle_a: assert property (
        !rd_i |=> rdata_o == 8'h00)
        else $error("read data present without a read");

    cover_ovf_c:   cover property (ovf_evt && mask_ff[`TCC8_FL_OVF]);
    cover_cmpa_c:  cover property (cmpa_evt ##1 int_req_o[`TCC8_FL_CMPA]);
    cover_ctc_c:   cover property (is_ctc && count_go && match_a);
    cover_phase_c: cover property (is_phase && count_go && down_ff && at_bottom);

endmodule // tcc8_core

// ==== tcc8_core_test.sv ====
`include "tcc8_regs.svh"

module tcc8_core_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk_i = 1'b0;
    logic       rst_b_i = 1'b0;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic       rd_d = 1'b0;
    logic       ext_pin = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [2:0] int_ack_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] v;
    logic [7:0] expq[$];
    wire  [7:0] rdata_o;
    wire  [2:0] int_req_o;
    wire        co_a;
    wire        co_b;
    int         err_count = 0;
    int         num_checks = 0;
    int         cyc = 0;
    int         n;
    int         p;

    always #20 clk_i = ~clk_i;

    tcc8_core u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .external_count_pin_i(ext_pin), .int_ack_i(int_ack_i),
        .int_req_o(int_req_o), .compare_output_a_o(co_a), .compare_output_b_o(co_b));

    // ------------------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task final_report;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // the write strobe is not cleared here, so back-to-back calls assign each signal once per step
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        rd_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        addr_i <= a;
        rd_i <= 1'b1;
        wr_i <= 1'b0;
        expq.push_back(e);
        @(posedge clk_i);
    endtask

    task automatic idle(input int c);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        repeat (c) @(posedge clk_i);
    endtask

    // ------------------------------------------------------------------------
    // read data monitor and hang guard
    // ------------------------------------------------------------------------
    always @(posedge clk_i) rd_d <= rd_i;
    always @(negedge clk_i) if (rd_d) chk("rdata", expq.pop_front(), rdata_o);

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report;
        end
    end

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        void'($urandom(32'h8222));
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        for (n = 0; n < 8; n++) rd(n[2:0], 8'h00);
        idle(2);
        chk("outputs", 8'h00, {3'h0, co_a, co_b, int_req_o});
        for (n = 2; n < 7; n++) if (n != 5) begin
            v = 8'($urandom);
            wr(n[2:0], v);
            rd(n[2:0], (n == 6) ? (v & 8'h07) : v);
        end
        wr(`TCC8_ADR_COUNTER, 8'h10);
        idle(20);
        rd(`TCC8_ADR_COUNTER, 8'h10);
        wr(`TCC8_ADR_CMP_A, 8'h20);
        wr(`TCC8_ADR_CMP_B, 8'h30);
        wr(`TCC8_ADR_MASK, 8'h07);
        wr(`TCC8_ADR_CTRL_B, 8'h01);
        idle(300);
        wr(`TCC8_ADR_CTRL_B, 8'h00);
        idle(3);
        rd(`TCC8_ADR_FLAGS, 8'h07);
        idle(2);
        chk("int_req", 8'h07, {5'h0, int_req_o});
        wr(`TCC8_ADR_FLAGS, 8'h02);
        rd(`TCC8_ADR_FLAGS, 8'h05);
        wr(`TCC8_ADR_MASK, 8'h01);
        idle(2);
        chk("int_req", 8'h01, {5'h0, int_req_o});
        int_ack_i <= 3'h1;
        @(posedge clk_i);
        int_ack_i <= 3'h0;
        rd(`TCC8_ADR_FLAGS, 8'h04);
        // running counter: the write must win over the tick at the same edge
        wr(`TCC8_ADR_CTRL_B, 8'h01);
        idle(3);
        v = 8'($urandom);
        wr(`TCC8_ADR_COUNTER, v);
        rd(`TCC8_ADR_COUNTER, v);
        wr(`TCC8_ADR_CTRL_B, 8'h00);
        idle(3);
        wr(`TCC8_ADR_CMP_A, 8'h05);
        wr(`TCC8_ADR_CMP_B, 8'h80);
        wr(`TCC8_ADR_COUNTER, 8'h00);
        wr(`TCC8_ADR_FLAGS, 8'h07);
        wr(`TCC8_ADR_CTRL_A, 8'h02);
        wr(`TCC8_ADR_CTRL_B, 8'h01);
        idle(100);
        wr(`TCC8_ADR_CTRL_B, 8'h00);
        idle(3);
        rd(`TCC8_ADR_FLAGS, 8'h02);
        wr(`TCC8_ADR_CTRL_A, 8'h00);
        for (n = 6; n < 8; n++) begin
            p = 1 + $urandom % 8;
            wr(`TCC8_ADR_COUNTER, 8'h00);
            wr(`TCC8_ADR_CTRL_B, n[7:0]);
            idle(2);
            repeat (p) begin
                ext_pin <= 1'b1;
                idle(4);
                ext_pin <= 1'b0;
                idle(4);
            end
            wr(`TCC8_ADR_CTRL_B, 8'h00);
            idle(3);
            rd(`TCC8_ADR_COUNTER, p[7:0]);
        end
        // divide by eight: 80 clock edges with the source on give exactly ten ticks
        wr(`TCC8_ADR_COUNTER, 8'h00);
        wr(`TCC8_ADR_CTRL_B, 8'h02);
        idle(79);
        wr(`TCC8_ADR_CTRL_B, 8'h00);
        idle(2);
        rd(`TCC8_ADR_COUNTER, 8'h0a);
        wr(`TCC8_ADR_CTRL_A, 8'h70);
        wr(`TCC8_ADR_CTRL_B, 8'hc0);
        idle(2);
        chk("wave", 8'h03, {6'h0, co_a, co_b});
        wr(`TCC8_ADR_CTRL_B, 8'hc0);
        idle(2);
        chk("wave", 8'h01, {6'h0, co_a, co_b});
        // phase correct: six ticks from 0xfd turn at the top, output A cleared up and set down
        wr(`TCC8_ADR_CMP_A, 8'hfe);
        wr(`TCC8_ADR_COUNTER, 8'hfd);
        wr(`TCC8_ADR_CTRL_A, 8'h81);
        wr(`TCC8_ADR_CTRL_B, 8'h01);
        idle(5);
        wr(`TCC8_ADR_CTRL_B, 8'h00);
        idle(2);
        rd(`TCC8_ADR_COUNTER, 8'hfb);
        idle(2);
        chk("wave", 8'h03, {6'h0, co_a, co_b});
        idle(3);
        final_report;
    end
endmodule // tcc8_core_test
